// ==== rtl/mie_core.sv ====
// Operation
// (RQ1) only listed flags change per instruction
// (RQ2) product/divide take 5 cycles, half-carry kept
// (RQ3) 33 rotates acc left through carry
// (RQ4) 13 rotates acc right through carry
// (RQ5) signed offset added to advanced counter
// (RQ6) B5 compares acc with direct, branches
// (RQ7) B4 compares acc with immediate, pc+3
// (RQ8) B8-BF compare bank register with immediate
// (RQ9) B6-B7 compare indirect byte with immediate
// (RQ10) D8-DF decrement bank register, branch nonzero
// (RQ11) D5 decrement direct byte, write, branch
// (RQ12) 70/60 branch on acc nonzero/zero
// (RQ13) 40/50 branch on carry set/clear
// (RQ14) indirect address from pointer R0 or R1
// (RQ15) bcd adjust adds six per nibble
// (RQ16) parity always tracks acc bit count
`timescale 1ns/1ns
`default_nettype none
module mie_core (
  input wire logic clk,
  input wire logic rst,
  output logic [mie_pkg::PC_W-1:0] prog_addr,
  input wire logic [mie_pkg::DW-1:0] prog_data,
  output logic [mie_pkg::DW-1:0] ram_addr,
  output logic ram_rd,
  output logic ram_wr,
  output logic [mie_pkg::DW-1:0] ram_wdata,
  input wire logic [mie_pkg::DW-1:0] ram_rdata,
  input wire logic [mie_pkg::REG_AW-1:0] reg_addr,
  input wire logic [mie_pkg::DW-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [mie_pkg::DW-1:0] reg_rdata,
  output logic insn_done
);
  import mie_pkg::*;

  function automatic logic is_alu(input logic [7:0] op);
    if (op inside {OP_ZERO_ACC, OP_LOAD_IMM}) return op == OP_LOAD_IMM;
    return (op[3:0] >= LO_IMM) && (op[7:4] inside {GRP_ADD, GRP_ADD_CARRY,
      GRP_OR, GRP_AND, GRP_XOR, GRP_SUB_BORROW, GRP_MOVE_ACC});
  endfunction

  function automatic logic is_short_branch(input logic [7:0] op);
    return op inside {OP_BRANCH_IF_CARRY, OP_BRANCH_IF_NO_CARRY,
      OP_BRANCH_IF_ACC_ZERO, OP_BRANCH_IF_ACC_NONZERO, OP_SHORT_JUMP};
  endfunction

  function automatic logic is_compare(input logic [7:0] op);
    return (op[7:4] == GRP_COMPARE) && (op[3:0] >= LO_IMM);
  endfunction

  function automatic logic is_dec_reg(input logic [7:0] op);
    return (op[7:4] == GRP_DECREMENT) && op[3];
  endfunction

  function automatic logic [1:0] op_len(input logic [7:0] op);
    if (is_alu(op) && op[3:0] <= LO_DIRECT) return LEN_TWO;
    if (is_compare(op) || op == OP_DECREMENT_DIR) return LEN_THREE;
    if (is_short_branch(op) || is_dec_reg(op)) return LEN_TWO;
    return LEN_ONE;
  endfunction

  function automatic logic [2:0] op_cycles(input logic [7:0] op);
    if (op == OP_PRODUCT || op == OP_DIVIDE) return CYC_PRODUCT; // [RQ2]
    if (is_compare(op) || op == OP_DECREMENT_DIR) return CYC_COMPARE;
    if (is_short_branch(op) || is_dec_reg(op)) return CYC_BRANCH;
    if (is_alu(op) && op[3:0] <= LO_DIRECT) return CYC_TWO;
    return CYC_ONE;
  endfunction

  // bank register for x8-xF, pointer R0/R1 by bit 0 otherwise
  function automatic logic [7:0] bank_addr(input logic [7:0] op,
                                           input logic [7:0] psw);
    logic [2:0] idx;
    idx = op[3] ? op[2:0] : {2'b00, op[0]}; // [RQ14]
    return {3'b000, psw[4:3], idx};
  endfunction

  // returns {carry, half carry, signed range, result}
  function automatic logic [10:0] alu_add(input logic [7:0] a,
                                          input logic [7:0] d,
                                          input logic cin,
                                          input logic sub);
    logic [8:0] full;
    logic [4:0] low;
    logic rng;
    if (sub) begin
      full = {1'b0, a} - {1'b0, d} - {8'h00, cin};
      low = {1'b0, a[3:0]} - {1'b0, d[3:0]} - {4'h0, cin};
      rng = (a[7] ^ d[7]) & (full[7] ^ a[7]);
    end else begin
      full = {1'b0, a} + {1'b0, d} + {8'h00, cin};
      low = {1'b0, a[3:0]} + {1'b0, d[3:0]} + {4'h0, cin};
      rng = (a[7] ~^ d[7]) & (full[7] ^ a[7]);
    end
    return {full[8], low[4], rng, full[7:0]};
  endfunction

  mie_state_type state_ff;
  mie_state_type nxt_state;
  logic [7:0] psw_full;
  logic [7:0] dval;
  logic [7:0] operand;
  logic [7:0] rel;
  logic [PC_W-1:0] seq_pc;
  logic [PC_W-1:0] target;
  logic [7:0] dec_reg;
  logic [7:0] dec_dir;
  logic taken;
  logic [10:0] alu_res;
  logic [15:0] prod;
  logic [7:0] quo;
  logic [7:0] rem;
  logic [8:0] bcd;
  logic [5:0] last_tick;

  always_comb begin
    // parity is derived, never stored, so no instruction can stale it
    psw_full = {state_ff.psw[7:1], ^state_ff.acc}; // [RQ16]
    if (state_ff.b1 == SFR_ACC) begin
      dval = state_ff.acc;
    end else if (state_ff.b1 == SFR_B) begin
      dval = state_ff.b;
    end else if (state_ff.b1 == SFR_PSW) begin
      dval = psw_full;
    end else begin
      dval = ram_rdata;
    end
    if (state_ff.op[3:0] == LO_IMM) begin
      operand = state_ff.b1;
    end else if (state_ff.op[3:0] == LO_DIRECT) begin
      operand = dval;
    end else if (state_ff.op[3]) begin
      operand = state_ff.regv;
    end else begin
      operand = ram_rdata;
    end
    rel = (op_len(state_ff.op) == LEN_THREE) ? state_ff.b2 : state_ff.b1;
    seq_pc = state_ff.pc + {{(PC_W-2){1'b0}}, op_len(state_ff.op)};
    target = seq_pc + {{8{rel[7]}}, rel}; // [RQ5]
    dec_reg = state_ff.regv - 8'h01;
    dec_dir = dval - 8'h01;
    taken = 1'b0;
    case (state_ff.op)
      OP_BRANCH_IF_CARRY: taken = state_ff.psw[PSW_CARRY]; // [RQ13]
      OP_BRANCH_IF_NO_CARRY: taken = !state_ff.psw[PSW_CARRY]; // [RQ13]
      OP_BRANCH_IF_ACC_ZERO: taken = (state_ff.acc == 8'h00); // [RQ12]
      OP_BRANCH_IF_ACC_NONZERO: taken = (state_ff.acc != 8'h00); // [RQ12]
      OP_SHORT_JUMP: taken = 1'b1;
      OP_COMPARE_IMM: taken = (state_ff.acc != state_ff.b1); // [RQ7]
      OP_COMPARE_DIR: taken = (state_ff.acc != dval); // [RQ6]
      OP_DECREMENT_DIR: taken = (dec_dir != 8'h00); // [RQ11]
      default: begin
        if (is_compare(state_ff.op) && state_ff.op[3]) begin
          taken = (state_ff.regv != state_ff.b1); // [RQ8]
        end else if (is_compare(state_ff.op)) begin
          taken = (ram_rdata != state_ff.b1); // [RQ9]
        end else if (is_dec_reg(state_ff.op)) begin
          taken = (dec_reg != 8'h00); // [RQ10]
        end
      end
    endcase
    alu_res = alu_add(state_ff.acc, operand,
      (state_ff.op[7:4] != GRP_ADD) & state_ff.psw[PSW_CARRY],
      state_ff.op[7:4] == GRP_SUB_BORROW);
    prod = {8'h00, state_ff.acc} * {8'h00, state_ff.b};
    quo = (state_ff.b == 8'h00) ? 8'h00 : state_ff.acc / state_ff.b;
    rem = (state_ff.b == 8'h00) ? 8'h00 : state_ff.acc % state_ff.b;
    bcd = {1'b0, state_ff.acc};
    if (state_ff.acc[3:0] > BCD_LIMIT || state_ff.psw[PSW_HALF_CARRY]) begin
      bcd = bcd + BCD_LO_FIX; // [RQ15]
    end
    if (bcd[7:4] > BCD_LIMIT || state_ff.psw[PSW_CARRY] || bcd[8]) begin
      bcd = bcd + BCD_HI_FIX; // [RQ15]
    end
    last_tick = 6'(op_cycles(state_ff.op)) * 6'(MCYC_CLKS) - 6'h01;

    nxt_state = state_ff;
    nxt_state.ram_rd = 1'b0;
    nxt_state.ram_wr = 1'b0;
    nxt_state.done = 1'b0;
    nxt_state.reg_rdata = 8'h00;
    if (reg_rd) begin
      case (reg_addr)
        REG_CTRL: nxt_state.reg_rdata = {7'h00, state_ff.run};
        REG_PSW: nxt_state.reg_rdata = psw_full;
        REG_ACC: nxt_state.reg_rdata = state_ff.acc;
        REG_B: nxt_state.reg_rdata = state_ff.b;
        REG_PC_LO: nxt_state.reg_rdata = state_ff.pc[7:0];
        REG_PC_HI: nxt_state.reg_rdata = state_ff.pc[15:8];
        default: nxt_state.reg_rdata = 8'h00;
      endcase
    end
    if (reg_wr && reg_addr == REG_CTRL) begin
      nxt_state.run = reg_wdata[CTRL_RUN];
    end

    unique case (state_ff.phase)
      PH_HALT: begin
        nxt_state.tick = 6'h00;
        if (state_ff.run) begin
          nxt_state.phase = PH_EXEC;
        end
      end
      PH_EXEC: begin
        nxt_state.tick = state_ff.tick + 6'h01;
        if (state_ff.tick == T_OP_ADDR) begin
          nxt_state.prog_addr = state_ff.pc;
        end
        if (state_ff.tick == T_B1_ADDR) begin
          nxt_state.prog_addr = state_ff.pc + 16'h0001;
        end
        if (state_ff.tick == T_OPCODE) begin
          nxt_state.op = prog_data;
          nxt_state.prog_addr = state_ff.pc + 16'h0002;
          nxt_state.ram_addr = bank_addr(prog_data, state_ff.psw);
          nxt_state.ram_rd = 1'b1;
        end
        if (state_ff.tick == T_BYTE1) begin
          nxt_state.b1 = prog_data;
        end
        if (state_ff.tick == T_BYTE2) begin
          nxt_state.b2 = prog_data;
          nxt_state.regv = ram_rdata;
          // x6/x7 fetch through the pointer, others by direct address
          nxt_state.ram_addr = (state_ff.op[3:1] == 3'b011) ?
            ram_rdata : state_ff.b1; // [RQ14]
          nxt_state.ram_rd = 1'b1;
        end
        if (state_ff.tick == T_EXEC) begin
          nxt_state.pc = taken ? target : seq_pc; // [RQ5] [RQ7]
          // each arm touches only its own flags [RQ1]
          case (state_ff.op)
            OP_PRODUCT: begin
              {nxt_state.b, nxt_state.acc} = prod; // [RQ2]
              nxt_state.psw[PSW_SIGNED_RANGE] = (prod[15:8] != 8'h00);
              nxt_state.psw[PSW_CARRY] = 1'b0;
            end
            OP_DIVIDE: begin
              // divide by zero leaves a and b as they were
              if (state_ff.b != 8'h00) begin
                nxt_state.acc = quo; // [RQ2]
                nxt_state.b = rem;
              end
              nxt_state.psw[PSW_SIGNED_RANGE] = (state_ff.b == 8'h00);
              nxt_state.psw[PSW_CARRY] = 1'b0;
            end
            OP_ROTATE_LEFT_THRU_CARRY: begin
              nxt_state.acc = {state_ff.acc[6:0], state_ff.psw[PSW_CARRY]};
              nxt_state.psw[PSW_CARRY] = state_ff.acc[7]; // [RQ3]
            end
            OP_ROTATE_RIGHT_THRU_CARRY: begin
              nxt_state.acc = {state_ff.psw[PSW_CARRY], state_ff.acc[7:1]};
              nxt_state.psw[PSW_CARRY] = state_ff.acc[0]; // [RQ4]
            end
            OP_ROTATE_LEFT: nxt_state.acc = {state_ff.acc[6:0],
              state_ff.acc[7]};
            OP_ROTATE_RIGHT: nxt_state.acc = {state_ff.acc[0],
              state_ff.acc[7:1]};
            OP_SWAP_NIBBLES: nxt_state.acc = {state_ff.acc[3:0],
              state_ff.acc[7:4]};
            OP_INVERT_ACC: nxt_state.acc = ~state_ff.acc;
            OP_ZERO_ACC: nxt_state.acc = 8'h00;
            OP_INC_ACC: nxt_state.acc = state_ff.acc + 8'h01;
            OP_DEC_ACC: nxt_state.acc = state_ff.acc - 8'h01;
            OP_CLEAR_CARRY: nxt_state.psw[PSW_CARRY] = 1'b0;
            OP_SET_CARRY: nxt_state.psw[PSW_CARRY] = 1'b1;
            OP_INVERT_CARRY: nxt_state.psw[PSW_CARRY] =
              !state_ff.psw[PSW_CARRY];
            OP_BCD_ADJUST: begin
              nxt_state.acc = bcd[7:0]; // [RQ15]
              if (bcd[8]) begin
                nxt_state.psw[PSW_CARRY] = 1'b1;
              end
            end
            OP_DECREMENT_DIR: begin
              if (state_ff.b1 == SFR_ACC) begin
                nxt_state.acc = dec_dir; // [RQ11]
              end else if (state_ff.b1 == SFR_B) begin
                nxt_state.b = dec_dir;
              end else begin
                nxt_state.ram_addr = state_ff.b1; // [RQ11]
                nxt_state.ram_wdata = dec_dir;
                nxt_state.ram_wr = 1'b1;
              end
            end
            default: begin
              if (is_dec_reg(state_ff.op)) begin
                nxt_state.ram_addr = bank_addr(state_ff.op, state_ff.psw);
                nxt_state.ram_wdata = dec_reg; // [RQ10]
                nxt_state.ram_wr = 1'b1;
              end else if (is_alu(state_ff.op)) begin
                case (state_ff.op[7:4])
                  GRP_ADD, GRP_ADD_CARRY, GRP_SUB_BORROW: begin
                    nxt_state.acc = alu_res[7:0];
                    nxt_state.psw[PSW_CARRY] = alu_res[10];
                    nxt_state.psw[PSW_HALF_CARRY] = alu_res[9];
                    nxt_state.psw[PSW_SIGNED_RANGE] = alu_res[8];
                  end
                  GRP_OR: nxt_state.acc = state_ff.acc | operand;
                  GRP_AND: nxt_state.acc = state_ff.acc & operand;
                  GRP_XOR: nxt_state.acc = state_ff.acc ^ operand;
                  default: nxt_state.acc = operand;
                endcase
              end
            end
          endcase
        end
        // cycle budget padded out to the documented count
        if (state_ff.tick == last_tick) begin
          nxt_state.tick = 6'h00; // [RQ2] [RQ6] [RQ10] [RQ11] [RQ12]
          nxt_state.done = 1'b1;
          if (!state_ff.run) begin
            nxt_state.phase = PH_HALT;
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_ff <= STATE_RESET;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign prog_addr = state_ff.prog_addr;
  assign ram_addr = state_ff.ram_addr;
  assign ram_rd = state_ff.ram_rd;
  assign ram_wr = state_ff.ram_wr;
  assign ram_wdata = state_ff.ram_wdata;
  assign reg_rdata = state_ff.reg_rdata;
  assign insn_done = state_ff.done;
endmodule
`default_nettype wire

// ==== rtl/mie_pkg.sv ====
package mie_pkg;
  localparam int PC_W = 16;
  localparam int DW = 8;
  localparam int REG_AW = 3;
  localparam int CLK_PERIOD_NS = 50;
  // clocks spent per instruction cycle of the opcode table
  localparam int MCYC_CLKS = 8;

  // sequencer ticks inside one instruction
  localparam logic [5:0] T_OP_ADDR = 6'h00;
  localparam logic [5:0] T_B1_ADDR = 6'h01;
  localparam logic [5:0] T_OPCODE = 6'h02;
  localparam logic [5:0] T_BYTE1 = 6'h03;
  localparam logic [5:0] T_BYTE2 = 6'h04;
  localparam logic [5:0] T_EXEC = 6'h06;

  localparam logic [2:0] CYC_ONE = 3'h1;
  localparam logic [2:0] CYC_TWO = 3'h2;
  localparam logic [2:0] CYC_BRANCH = 3'h3;
  localparam logic [2:0] CYC_COMPARE = 3'h4;
  localparam logic [2:0] CYC_PRODUCT = 3'h5;
  localparam logic [1:0] LEN_ONE = 2'h1;
  localparam logic [1:0] LEN_TWO = 2'h2;
  localparam logic [1:0] LEN_THREE = 2'h3;

  localparam logic [7:0] OP_PRODUCT = 8'ha4;
  localparam logic [7:0] OP_DIVIDE = 8'h84;
  localparam logic [7:0] OP_ROTATE_LEFT_THRU_CARRY = 8'h33;
  localparam logic [7:0] OP_ROTATE_RIGHT_THRU_CARRY = 8'h13;
  localparam logic [7:0] OP_ROTATE_LEFT = 8'h23;
  localparam logic [7:0] OP_ROTATE_RIGHT = 8'h03;
  localparam logic [7:0] OP_SWAP_NIBBLES = 8'hc4;
  localparam logic [7:0] OP_INVERT_ACC = 8'hf4;
  localparam logic [7:0] OP_ZERO_ACC = 8'he4;
  localparam logic [7:0] OP_INC_ACC = 8'h04;
  localparam logic [7:0] OP_DEC_ACC = 8'h14;
  localparam logic [7:0] OP_CLEAR_CARRY = 8'hc3;
  localparam logic [7:0] OP_SET_CARRY = 8'hd3;
  localparam logic [7:0] OP_INVERT_CARRY = 8'hb3;
  localparam logic [7:0] OP_BCD_ADJUST = 8'hd4;
  localparam logic [7:0] OP_BRANCH_IF_CARRY = 8'h40;
  localparam logic [7:0] OP_BRANCH_IF_NO_CARRY = 8'h50;
  localparam logic [7:0] OP_BRANCH_IF_ACC_ZERO = 8'h60;
  localparam logic [7:0] OP_BRANCH_IF_ACC_NONZERO = 8'h70;
  localparam logic [7:0] OP_SHORT_JUMP = 8'h80;
  localparam logic [7:0] OP_COMPARE_IMM = 8'hb4;
  localparam logic [7:0] OP_COMPARE_DIR = 8'hb5;
  localparam logic [7:0] OP_DECREMENT_DIR = 8'hd5;
  localparam logic [7:0] OP_LOAD_IMM = 8'h74;

  // high nibbles of opcode groups, then low nibbles of the immediate and direct forms
  localparam logic [3:0] GRP_ADD = 4'h2;
  localparam logic [3:0] GRP_ADD_CARRY = 4'h3;
  localparam logic [3:0] GRP_OR = 4'h4;
  localparam logic [3:0] GRP_AND = 4'h5;
  localparam logic [3:0] GRP_XOR = 4'h6;
  localparam logic [3:0] GRP_SUB_BORROW = 4'h9;
  localparam logic [3:0] GRP_COMPARE = 4'hb;
  localparam logic [3:0] GRP_DECREMENT = 4'hd;
  localparam logic [3:0] GRP_MOVE_ACC = 4'he;
  localparam logic [3:0] LO_IMM = 4'h4;
  localparam logic [3:0] LO_DIRECT = 4'h5;

  localparam int PSW_CARRY = 7;
  localparam int PSW_HALF_CARRY = 6;
  localparam int PSW_SIGNED_RANGE = 2;

  localparam logic [7:0] SFR_ACC = 8'he0;
  localparam logic [7:0] SFR_B = 8'hf0;
  localparam logic [7:0] SFR_PSW = 8'hd0;

  localparam logic [REG_AW-1:0] REG_CTRL = 3'h0;
  localparam logic [REG_AW-1:0] REG_PSW = 3'h1;
  localparam logic [REG_AW-1:0] REG_ACC = 3'h2;
  localparam logic [REG_AW-1:0] REG_B = 3'h3;
  localparam logic [REG_AW-1:0] REG_PC_LO = 3'h4;
  localparam logic [REG_AW-1:0] REG_PC_HI = 3'h5;
  localparam int CTRL_RUN = 0;

  localparam logic [3:0] BCD_LIMIT = 4'h9;
  localparam logic [8:0] BCD_LO_FIX = 9'h006;
  localparam logic [8:0] BCD_HI_FIX = 9'h060;

  typedef enum logic {PH_HALT, PH_EXEC} mie_phase_type;

  typedef struct packed {
    mie_phase_type phase;
    logic [5:0] tick;
    logic [PC_W-1:0] pc;
    logic [7:0] op;
    logic [7:0] b1;
    logic [7:0] b2;
    logic [7:0] regv;
    logic [7:0] acc;
    logic [7:0] b;
    logic [7:0] psw;
    logic run;
    logic done;
    logic [PC_W-1:0] prog_addr;
    logic [7:0] ram_addr;
    logic [7:0] ram_wdata;
    logic ram_rd;
    logic ram_wr;
    logic [7:0] reg_rdata;
  } mie_state_type;

  localparam mie_state_type STATE_RESET = '{phase: PH_HALT, tick: 6'h00,
    pc: 16'h0000, op: 8'h00, b1: 8'h00, b2: 8'h00, regv: 8'h00,
    acc: 8'h00, b: 8'h00, psw: 8'h00, run: 1'b1, done: 1'b0,
    prog_addr: 16'h0000, ram_addr: 8'h00, ram_wdata: 8'h00,
    ram_rd: 1'b0, ram_wr: 1'b0, reg_rdata: 8'h00};
endpackage

// ==== testbench/mie_core_chk.sv ====
`timescale 1ns/1ns
`default_nettype none
module mie_core_chk (
  input wire logic clk,
  input wire logic rst,
  input wire logic [mie_pkg::PC_W-1:0] prog_addr,
  input wire logic [mie_pkg::DW-1:0] prog_data,
  input wire logic [mie_pkg::DW-1:0] ram_addr,
  input wire logic ram_rd,
  input wire logic ram_wr,
  input wire logic [mie_pkg::DW-1:0] ram_wdata,
  input wire logic [mie_pkg::DW-1:0] ram_rdata,
  input wire logic [mie_pkg::REG_AW-1:0] reg_addr,
  input wire logic [mie_pkg::DW-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [mie_pkg::DW-1:0] reg_rdata,
  input wire logic insn_done
);
  import mie_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // opcode shows on prog_data two cycles after the done pulse
  property p_muldiv;
    insn_done ##2 (prog_data == OP_PRODUCT || prog_data == OP_DIVIDE)
      |-> ##38 insn_done;
  endproperty
  a_muldiv: assert property (p_muldiv)
    else $error("product or divide length wrong");
  property p_cmp_dir;
    insn_done ##2 (prog_data == OP_COMPARE_DIR) |-> ##30 insn_done;
  endproperty
  a_cmp_dir: assert property (p_cmp_dir)
    else $error("compare direct length wrong");
  property p_dec_reg;
    insn_done ##2 (prog_data[7:3] == 5'h1b) |-> ##22 insn_done;
  endproperty
  a_dec_reg: assert property (p_dec_reg)
    else $error("register decrement length wrong");
  property p_dec_dir;
    insn_done ##2 (prog_data == OP_DECREMENT_DIR) |-> ##30 insn_done;
  endproperty
  a_dec_dir: assert property (p_dec_dir)
    else $error("direct decrement length wrong");
  property p_acc_br;
    insn_done ##2 (prog_data == OP_BRANCH_IF_ACC_ZERO ||
      prog_data == OP_BRANCH_IF_ACC_NONZERO) |-> ##22 insn_done;
  endproperty
  a_acc_br: assert property (p_acc_br)
    else $error("accumulator branch length wrong");
  property p_cy_br;
    insn_done ##2 (prog_data == OP_BRANCH_IF_CARRY ||
      prog_data == OP_BRANCH_IF_NO_CARRY) |-> ##22 insn_done;
  endproperty
  a_cy_br: assert property (p_cy_br)
    else $error("carry branch length wrong");
  property p_indirect;
    insn_done ##2 (prog_data[3:1] == 3'h3)
      |-> ##3 (ram_rd && ram_addr == $past(ram_rdata));
  endproperty
  a_indirect: assert property (p_indirect)
    else $error("indirect address not taken from pointer");
  property p_bank;
    insn_done ##2 prog_data[3]
      |=> (ram_rd && ram_addr[2:0] == $past(prog_data[2:0]));
  endproperty
  a_bank: assert property (p_bank)
    else $error("bank register address wrong");
  property p_wr_data;
    ram_wr |-> (ram_wdata == $past(ram_rdata) - 8'h01 ||
      ram_wdata == $past(ram_rdata, 3) - 8'h01);
  endproperty
  a_wr_data: assert property (p_wr_data)
    else $error("written value is not the decrement");
  property p_wr_order;
    ram_wr |-> ($past(ram_rd, 2) && !ram_rd);
  endproperty
  a_wr_order: assert property (p_wr_order)
    else $error("write not two cycles after read");
endmodule
`default_nettype wire

// ==== testbench/mie_mem.sv ====
`timescale 1ns/1ns
`default_nettype none
module mie_mem (
  input wire logic clk,
  input wire logic rst,
  input wire logic [mie_pkg::PC_W-1:0] prog_addr,
  output logic [mie_pkg::DW-1:0] prog_data,
  input wire logic [mie_pkg::DW-1:0] ram_addr,
  input wire logic ram_rd,
  input wire logic ram_wr,
  input wire logic [mie_pkg::DW-1:0] ram_wdata,
  output logic [mie_pkg::DW-1:0] ram_rdata
);
  import mie_pkg::*;
  // only 256 program bytes, the address wraps above that
  logic [7:0] rom [256];
  logic [7:0] ram [256];
  always @(posedge clk) begin
    prog_data <= rom[prog_addr[7:0]];
    if (ram_wr) ram[ram_addr] <= ram_wdata;
  end
  // toggles outside the read slot so a late sample sees garbage
  always @(posedge clk or posedge rst) begin
    if (rst) ram_rdata <= 8'h00;
    else if (ram_rd) ram_rdata <= ram[ram_addr];
    else ram_rdata <= ~ram_rdata;
  end
endmodule
`default_nettype wire

// ==== testbench/testbench.sv ====
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import mie_pkg::*;
  localparam logic [415:0] PROG = {128'h7496d33313c31304400250020000b44c,
    128'h05b4000100dafed530fdb5310100bb05,
    128'h0100b633016001700100d5f0002404a4, 32'h84d480fe};
  // acc, psw, b, pc low, clocks since previous done (0: skip)
  localparam logic [39:0] EXP [25] = '{
    40'h9600000200, 40'h9680000308, 40'h2d80000408, 40'h9680000508,
    40'h9600000608, 40'h4b00000708, 40'h4c01000808, 40'h4c01000a18,
    40'h4c01000e18, 40'h4c01001120, 40'h4c01001520, 40'h4c01001518,
    40'h4c01001718, 40'h4c01001a20, 40'h4c01001e20, 40'h4c01002220,
    40'h4c01002520, 40'h4c01002718, 40'h4c01002a18, 40'h4c01ff2d20,
    40'h5040ff2f10, 40'hb0454f3028, 40'h0241123128, 40'h0841123208,
    40'h0841123218};
  localparam logic [11:0] RA = {REG_PC_LO, REG_B, REG_PSW, REG_ACC};
  logic clk, rst, reg_wr, reg_rd, ram_rd, ram_wr, insn_done;
  logic [PC_W-1:0] prog_addr;
  logic [7:0] prog_data, ram_addr, ram_wdata, ram_rdata;
  logic [7:0] reg_wdata, reg_rdata, cnt, span, v;
  logic [REG_AW-1:0] reg_addr;
  logic [31:0] got;
  int n_errors, checks;
  mie_core u_mie_core (.clk(clk), .rst(rst), .prog_addr(prog_addr),
    .prog_data(prog_data), .ram_addr(ram_addr), .ram_rd(ram_rd),
    .ram_wr(ram_wr), .ram_wdata(ram_wdata), .ram_rdata(ram_rdata),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .insn_done(insn_done));
  mie_mem u_mie_mem (.clk(clk), .rst(rst), .prog_addr(prog_addr),
    .prog_data(prog_data), .ram_addr(ram_addr), .ram_rd(ram_rd),
    .ram_wr(ram_wr), .ram_wdata(ram_wdata), .ram_rdata(ram_rdata));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // clocks between consecutive done pulses
  always @(posedge clk) begin
    if (rst) begin
      cnt <= 8'h00;
      span <= 8'h00;
    end else if (insn_done === 1'b1) begin
      span <= cnt;
      cnt <= 8'h01;
    end else cnt <= cnt + 8'h01;
  end
  task automatic chk(input string nm, input logic [7:0] e,
    input logic [7:0] g);
    checks++;
    if (g !== e) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic summarize();
    $display("errors %0d checks %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic wait_done();
    int t;
    t = 0;
    do begin
      @(negedge clk);
      t++;
    end while (insn_done !== 1'b1 && t < 100);
    if (t >= 100) chk("done", 8'h01, 8'h00);
  endtask
  // back to back reads of acc, psw, b, pc low; data seen at negedge
  task automatic rd4(output logic [31:0] r);
    r = 32'h0;
    for (int k = 0; k < 5; k++) begin
      @(posedge clk);
      reg_rd <= (k < 4);
      reg_addr <= RA[3*(k%4) +: 3];
      if (k > 0) begin
        @(negedge clk);
        r = {r[23:0], reg_rdata};
      end
    end
  endtask
  task automatic rd1(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    d = reg_rdata;
  endtask
  task automatic wr1(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  initial begin
    rst = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = REG_CTRL;
    reg_wdata = 8'h00;
    n_errors = 0;
    checks = 0;
    for (int i = 0; i < 256; i++) begin
      u_mie_mem.ram[i] = 8'h00;
      u_mie_mem.rom[i] = 8'h00;
    end
    for (int i = 0; i < 52; i++) u_mie_mem.rom[i] = PROG[8*(51-i) +: 8];
    u_mie_mem.ram[8'h00] = 8'h40;
    u_mie_mem.ram[8'h02] = 8'h02;
    u_mie_mem.ram[8'h03] = 8'h07;
    u_mie_mem.ram[8'h30] = 8'h01;
    u_mie_mem.ram[8'h40] = 8'h33;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    for (int n = 0; n < 25; n++) begin
      wait_done();
      rd4(got);
      chk("acc", EXP[n][39:32], got[31:24]);
      chk("psw", EXP[n][31:24], got[23:16]);
      chk("b", EXP[n][23:16], got[15:8]);
      chk("pc", EXP[n][15:8], got[7:0]);
      if (EXP[n][7:0] != 8'h00) chk("clocks", EXP[n][7:0], span);
    end
    chk("bank reg", 8'h00, u_mie_mem.ram[8'h02]);
    chk("direct byte", 8'h00, u_mie_mem.ram[8'h30]);
    chk("b kept off ram", 8'h00, u_mie_mem.ram[8'hf0]);
    wr1(REG_PSW, 8'hff);
    rd1(REG_PSW, v);
    chk("psw read only", 8'h41, v);
    rd1(3'h6, v);
    chk("unmapped", 8'h00, v);
    // a halted core stops pulsing done and keeps its flags
    wr1(REG_CTRL, 8'h00);
    repeat (60) @(posedge clk);
    chk("halted", 8'h01, {7'h00, cnt > 8'h1e});
    rd1(REG_CTRL, v);
    chk("run bit", 8'h00, v);
    rd1(REG_PSW, v);
    chk("psw halted", 8'h41, v);
    wr1(REG_CTRL, 8'h01);
    wait_done();
    summarize();
  end
  initial begin
    #200000;
    n_errors++;
    summarize();
  end
endmodule
bind mie_core mie_core_chk u_mie_core_chk (.clk(clk), .rst(rst),
  .prog_addr(prog_addr), .prog_data(prog_data), .ram_addr(ram_addr),
  .ram_rd(ram_rd), .ram_wr(ram_wr), .ram_wdata(ram_wdata),
  .ram_rdata(ram_rdata), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .insn_done(insn_done));
`default_nettype wire
